//--- lsdf_consts.svh
// Purpose: offsets, field positions and reset values of the formatter
// Assumes: included by bare name, definitions only
// Notes:   all offsets are byte addresses on the register bus
`ifndef LSDF_CONSTS_SVH
`define LSDF_CONSTS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define ARITH_CTRL_OFS     12'h000
`define CONFIG_OFS         12'h004
`define STATUS_OFS         12'h008
`define COUNT_OFS          12'h00C

// ****************************************************************
// field positions
// ****************************************************************
`define OVF_FLAG_BIT       0
`define OVF_MASK_BIT       1
`define CFG_BIG_END_BIT    0
`define CFG_UNAL_FAULT_BIT 1
`define ST_UNAL_BIT        0
`define ST_OVF_BIT         1
`define ST_MISAL_BIT       2

// ****************************************************************
// reset values and size codes
// ****************************************************************
`define OVF_FLAG_RESET     1'h0
`define OVF_MASK_RESET     1'h0
`define BIG_END_RESET      1'h0
`define UNAL_FAULT_RESET   1'h0
`define UNIT_BYTE          2'h0
`define UNIT_HALF          2'h1
`define UNIT_WORD          2'h2

`endif

//--- lsdf_pkg.sv
// Purpose: types shared by the formatter modules
// Assumes: nothing beyond the constants header
// Notes:   operation codes follow enum order
package lsdf_pkg;

    // ****************************************************************
    // operations and register selects
    // ****************************************************************
    typedef enum logic [4:0] {
        OP_LD_BYTE_U, signed_byte_load, OP_LD_HALF_U,
        signed_halfword_load, OP_LD_WORD, double_word_load,
        OP_LD_TRIPLE, OP_LD_QUAD,
        OP_ST_BYTE_U, OP_ST_BYTE_S, OP_ST_HALF_U, OP_ST_HALF_S,
        OP_ST_WORD, OP_ST_LONG, OP_ST_TRIPLE, OP_ST_QUAD,
        OP_LITERAL
    } op_t;

    typedef enum logic [2:0] {
        SEL_ARITH, SEL_CONFIG, SEL_STATUS, SEL_COUNT, SEL_NONE
    } reg_sel_t;

endpackage

//--- fmt_if.sv
// Purpose: carries data between the formatter and its helpers
// Assumes: helpers are purely combinational
// Notes:   unit is the byte-swap unit, 0 byte, 1 halfword, 2 word
interface fmt_if;
    logic [127:0] ord_in;
    logic [127:0] ord_out;
    logic [1:0]   unit;
    logic         big_endian;
    logic [31:0]  ext_in;
    logic [1:0]   ext_size;
    logic         ext_signed;
    logic [31:0]  ext_out;
    logic         ext_ovf;

    modport orderer (input ord_in, unit, big_endian, output ord_out);
    modport extender (input ext_in, ext_size, ext_signed,
                      output ext_out, ext_ovf);
endinterface

//--- byte_orderer.sv
// Purpose: byte lane reordering for little or big endian accesses
// Assumes: lane 0 holds the byte at the lowest address
// Notes:   the swap is its own inverse, so loads and stores share it
module byte_orderer (
    fmt_if.orderer f
);
    `include "lsdf_consts.svh"

    // ****************************************************************
    // per-lane source select
    // ****************************************************************
    // big endian reverses bytes inside each unit; multiword keeps word
    // order so the lowest address word still lands lowest
    for (genvar i = 0; i < 16; i++) begin : g_lane
        logic [3:0] src;
        always_comb begin
            src = 4'(i);
            if (f.big_endian) begin
                case (f.unit)
                    `UNIT_HALF: src = 4'(i) ^ 4'h1;
                    `UNIT_WORD: src = 4'(i) ^ 4'h3;
                    default:    src = 4'(i);
                endcase
            end
        end
        assign f.ord_out[8*i +: 8] = f.ord_in[8*src +: 8];
    end
endmodule

//--- value_extender.sv
// Purpose: sign or zero extension and store overflow detection
// Assumes: value is right aligned, bit 0 least significant
// Notes:   word size passes through untouched
module value_extender (
    fmt_if.extender f
);
    `include "lsdf_consts.svh"

    // ****************************************************************
    // extension and fit check
    // ****************************************************************
    always_comb begin
        f.ext_out = f.ext_in;
        f.ext_ovf = 1'b0;
        case (f.ext_size)
            `UNIT_BYTE: begin
                f.ext_out = f.ext_signed ?
                    {{24{f.ext_in[7]}}, f.ext_in[7:0]} :
                    {24'h000000, f.ext_in[7:0]};
                // unsigned truncation never overflows
                f.ext_ovf = f.ext_signed &&
                    (f.ext_in[31:7] != {25{f.ext_in[7]}});
            end
            `UNIT_HALF: begin
                f.ext_out = f.ext_signed ?
                    {{16{f.ext_in[15]}}, f.ext_in[15:0]} :
                    {16'h0000, f.ext_in[15:0]};
                f.ext_ovf = f.ext_signed &&
                    (f.ext_in[31:15] != {17{f.ext_in[15]}});
            end
            default: begin
                f.ext_out = f.ext_in;
                f.ext_ovf = 1'b0;
            end
        endcase
    end
endmodule

//--- load_store_data_formatter.sv
// Purpose: formats load and store data between register file and memory
// Assumes: one request per cycle at most, answer one cycle later
// Notes:   APB slave answers with no wait state
// How it works
// - signed byte/halfword loads are sign-extended
// - signed narrow store truncates, flags overflow
// - mask bit picks flag or overflow fault
// - word transfers pass value unchanged
// - unsigned byte/halfword loads are zero-extended
// - unsigned narrow store truncates, never overflows
// - register bit 0 least, bit 31 most
// - bit fields stay inside one register
// - triple and quad words move unmodified
// - lowest memory word goes to lowest register
// - register groups need even or quad alignment
// - unaligned access completes, or faults when enabled
// - 5-bit literal expands with leading zeros
// - literal zero-extends to wider operand widths
// - little endian: lowest address least significant
// - big endian: lowest address most significant
// - in registers, bit 0 is always least
// - byte bits 0..7, higher bytes higher addresses
// - narrow data right aligned, upper bits filled
//
// The APB register port and the address map were decided locally.
module load_store_data_formatter
    import lsdf_pkg::*;
(
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [11:0]  paddr,
    input  wire logic [31:0]  pwdata,
    output logic      [31:0]  prdata,
    output logic              pready,
    output logic              pslverr,
    input  wire logic         req_valid,
    input  wire op_t          req_op,
    input  wire logic [31:0]  req_addr,
    input  wire logic [4:0]   req_reg_num,
    input  wire logic [4:0]   req_literal,
    input  wire logic [127:0] req_wdata,
    input  wire logic [127:0] mem_rdata,
    output logic              rsp_valid,
    output logic      [127:0] rsp_data,
    output logic      [15:0]  rsp_byte_en,
    output logic              rsp_overflow,
    output logic              rsp_ovf_fault,
    output logic              rsp_unal_fault,
    output logic              rsp_reg_misaligned
);
    `include "lsdf_consts.svh"

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic         ovf_flag;
        logic         ovf_mask;
        logic         big_endian;
        logic         unal_fault_en;
        logic [31:0]  prdata;
        logic         pslverr;
        logic         rsp_valid;
        logic [127:0] rsp_data;
        logic [15:0]  rsp_byte_en;
        logic         rsp_overflow;
        logic         rsp_ovf_fault;
        logic         rsp_unal_fault;
        logic         rsp_misal;
        logic [2:0]   last_status;
        logic [15:0]  access_count;
    } state_t;

    state_t st_reg;
    state_t st_next;

    fmt_if f ();

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // register select is decoded for both read setup and write access
    function automatic reg_sel_t decode_sel(input logic [11:0] a);
        case (a)
            `ARITH_CTRL_OFS: decode_sel = SEL_ARITH;
            `CONFIG_OFS:     decode_sel = SEL_CONFIG;
            `STATUS_OFS:     decode_sel = SEL_STATUS;
            `COUNT_OFS:      decode_sel = SEL_COUNT;
            default:         decode_sel = SEL_NONE;
        endcase
    endfunction

    // number of bytes moved by an operation
    function automatic logic [4:0] op_bytes(input op_t op);
        case (op)
            OP_LD_BYTE_U, signed_byte_load,
            OP_ST_BYTE_U, OP_ST_BYTE_S:       op_bytes = 5'h01;
            OP_LD_HALF_U, signed_halfword_load,
            OP_ST_HALF_U, OP_ST_HALF_S:       op_bytes = 5'h02;
            OP_LD_WORD, OP_ST_WORD:           op_bytes = 5'h04;
            double_word_load, OP_ST_LONG:     op_bytes = 5'h08;
            OP_LD_TRIPLE, OP_ST_TRIPLE:       op_bytes = 5'h0C;
            OP_LD_QUAD, OP_ST_QUAD:           op_bytes = 5'h10;
            default:                          op_bytes = 5'h00;
        endcase
    endfunction

    // byte lanes covered by a transfer of n bytes
    function automatic logic [15:0] lane_mask(input logic [4:0] n);
        logic [15:0] m;
        m = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            m[i] = (5'(i) < n);
        end
        lane_mask = m;
    endfunction

    // expand a lane mask to a bit mask
    function automatic logic [127:0] bit_mask(input logic [15:0] m);
        logic [127:0] b;
        b = 128'h0;
        for (int i = 0; i < 16; i++) begin
            b[8*i +: 8] = {8{m[i]}};
        end
        bit_mask = b;
    endfunction

    // ****************************************************************
    // request classification
    // ****************************************************************
    logic [4:0]   req_bytes;
    logic [15:0]  req_lanes;
    logic         req_is_load;
    logic         req_is_store;
    logic         req_is_lit;
    logic         req_signed;
    logic [1:0]   req_unit;
    logic         mem_misal;
    logic         reg_misal;
    logic [127:0] store_masked;

    assign req_bytes    = op_bytes(req_op);
    assign req_lanes    = lane_mask(req_bytes);
    assign req_is_lit   = (req_op == OP_LITERAL);
    assign req_is_load  = !req_is_lit && (req_op <= OP_LD_QUAD);
    assign req_is_store = !req_is_lit && !req_is_load;
    assign req_signed   = (req_op == signed_byte_load)
                       || (req_op == signed_halfword_load)
                       || (req_op == OP_ST_BYTE_S)
                       || (req_op == OP_ST_HALF_S);

    // multiword moves swap per word, never across words
    assign req_unit = (req_bytes == 5'h01) ? `UNIT_BYTE :
                      (req_bytes == 5'h02) ? `UNIT_HALF :
                                             `UNIT_WORD;

    // natural alignment of the memory address for the unit
    assign mem_misal = (req_unit == `UNIT_HALF) ? req_addr[0] :
                       (req_unit == `UNIT_WORD) ? (req_addr[1:0] != 2'h0) :
                                                  1'b0;

    // register groups: pairs even, three or four on a multiple of four
    assign reg_misal = (req_bytes == 5'h08) ? req_reg_num[0] :
                       (req_bytes >= 5'h0C) ?
                           (req_reg_num[1:0] != 2'h0) : 1'b0;

    // stores keep only the low part of the register group
    assign store_masked = req_wdata & bit_mask(req_lanes);

    // ****************************************************************
    // helper wiring
    // ****************************************************************
    // byte order comes from the config register as it stands at the
    // edge that takes the request, so a write in flight cannot split it
    assign f.ord_in     = req_is_load ? mem_rdata : store_masked;
    assign f.unit       = req_unit;
    assign f.big_endian = st_reg.big_endian;
    assign f.ext_in     = req_is_load ? f.ord_out[31:0] : req_wdata[31:0];
    assign f.ext_size   = req_unit;
    assign f.ext_signed = req_signed;

    byte_orderer u_orderer (
        .f (f.orderer)
    );

    value_extender u_extender (
        .f (f.extender)
    );

    // ****************************************************************
    // register bus decode
    // ****************************************************************
    reg_sel_t sel;
    logic     apb_setup;
    logic     apb_write;

    assign sel       = decode_sel(paddr);
    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next = st_reg;

        // response flags are single-cycle pulses
        st_next.rsp_valid      = 1'b0;
        st_next.rsp_overflow   = 1'b0;
        st_next.rsp_ovf_fault  = 1'b0;
        st_next.rsp_unal_fault = 1'b0;
        st_next.rsp_misal      = 1'b0;

        // read data is latched in setup so it comes from a flop
        if (apb_setup) begin
            st_next.pslverr = (sel == SEL_NONE);
            case (sel)
                SEL_ARITH: begin
                    st_next.prdata = 32'h00000000;
                    st_next.prdata[`OVF_FLAG_BIT] = st_reg.ovf_flag;
                    st_next.prdata[`OVF_MASK_BIT] = st_reg.ovf_mask;
                end
                SEL_CONFIG: begin
                    st_next.prdata = 32'h00000000;
                    st_next.prdata[`CFG_BIG_END_BIT] = st_reg.big_endian;
                    st_next.prdata[`CFG_UNAL_FAULT_BIT] =
                        st_reg.unal_fault_en;
                end
                SEL_STATUS: st_next.prdata = {29'h0, st_reg.last_status};
                SEL_COUNT:  st_next.prdata = {16'h0000, st_reg.access_count};
                default:    st_next.prdata = 32'h00000000;
            endcase
        end

        // writes land at the end of the access phase; status and count
        // are read only and silently keep their value
        if (apb_write) begin
            case (sel)
                SEL_ARITH: begin
                    if (pwdata[`OVF_FLAG_BIT]) begin
                        st_next.ovf_flag = 1'b0;
                    end
                    st_next.ovf_mask = pwdata[`OVF_MASK_BIT];
                end
                SEL_CONFIG: begin
                    st_next.big_endian    = pwdata[`CFG_BIG_END_BIT];
                    st_next.unal_fault_en = pwdata[`CFG_UNAL_FAULT_BIT];
                end
                default: ;
            endcase
        end

        // one access is formatted per request; result shows next cycle
        if (req_valid) begin
            st_next.rsp_valid    = 1'b1;
            st_next.access_count = st_reg.access_count + 16'h0001;
            st_next.rsp_misal    = reg_misal && !req_is_lit;
            st_next.rsp_byte_en  = 16'h0000;
            st_next.rsp_data     = 128'h0;

            if (req_is_lit) begin
                // literal is ordinal: leading zeros to any width
                st_next.rsp_data = {123'h0, req_literal};
            end else if (mem_misal && st_reg.unal_fault_en) begin
                // fault replaces the access; nothing is moved
                st_next.rsp_unal_fault = 1'b1;
            end else if (req_is_load) begin
                if (req_bytes <= 5'h04) begin
                    st_next.rsp_data = {96'h0, f.ext_out};
                end else begin
                    // word k of memory is register base plus k
                    st_next.rsp_data = f.ord_out &
                        bit_mask(req_lanes);
                end
            end else begin
                // unaligned accesses otherwise complete unchanged
                st_next.rsp_data    = f.ord_out;
                st_next.rsp_byte_en = req_lanes;
                if (f.ext_ovf) begin
                    st_next.rsp_overflow = 1'b1;
                    st_next.rsp_ovf_fault = !st_reg.ovf_mask;
                end
            end
        end

        // overflow flag is sticky; a new overflow beats a clear
        if (req_valid && req_is_store && !req_is_lit && f.ext_ovf
            && !(mem_misal && st_reg.unal_fault_en)
            && st_reg.ovf_mask) begin
            st_next.ovf_flag = 1'b1;
        end

        // status keeps the causes seen on the last response
        if (req_valid) begin
            st_next.last_status[`ST_UNAL_BIT] =
                st_next.rsp_unal_fault;
            st_next.last_status[`ST_OVF_BIT] = st_next.rsp_overflow;
            st_next.last_status[`ST_MISAL_BIT] = st_next.rsp_misal;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg               <= '0;
            st_reg.ovf_flag      <= `OVF_FLAG_RESET;
            st_reg.ovf_mask      <= `OVF_MASK_RESET;
            st_reg.big_endian    <= `BIG_END_RESET;
            st_reg.unal_fault_en <= `UNAL_FAULT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // zero wait states: data was captured during setup
    assign pready  = 1'b1;
    assign prdata  = st_reg.prdata;
    assign pslverr = st_reg.pslverr && psel && penable;

    // register words keep bit 0 as least significant; bit fields are
    // handled by the execution unit inside one such word
    assign rsp_valid          = st_reg.rsp_valid;
    assign rsp_data           = st_reg.rsp_data;
    assign rsp_byte_en        = st_reg.rsp_byte_en;
    assign rsp_overflow       = st_reg.rsp_overflow;
    assign rsp_ovf_fault      = st_reg.rsp_ovf_fault;
    assign rsp_unal_fault     = st_reg.rsp_unal_fault;
    assign rsp_reg_misaligned = st_reg.rsp_misal;

endmodule

//--- lsdf_monitor.sv
// Purpose: concurrent checks on the formatter request side
// Assumes: one cycle response latency, single clock domain
// Notes:   endian-dependent data is judged by the bench
module lsdf_monitor
    import lsdf_pkg::*;
(
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         req_valid,
    input wire op_t          req_op,
    input wire logic [4:0]   req_literal,
    input wire logic [127:0] req_wdata,
    input wire logic [127:0] mem_rdata,
    input wire logic         rsp_valid,
    input wire logic [127:0] rsp_data,
    input wire logic [15:0]  rsp_byte_en,
    input wire logic         rsp_overflow,
    input wire logic         rsp_ovf_fault,
    input wire logic         rsp_unal_fault
);
    logic       sb_fit;
    logic [7:0] w_lo;
    logic [7:0] m_lo;
    // a signed byte fits when bits 31:7 are all copies of one sign
    assign sb_fit = &req_wdata[31:7] | ~|req_wdata[31:7];
    assign w_lo = req_wdata[7:0];
    assign m_lo = mem_rdata[7:0];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rsp_latency: assert property (rsp_valid == $past(req_valid))
        else $error("response strobe not one cycle after request");
    a_sbyte_sign: assert property (req_valid && req_op == signed_byte_load
        |=> rsp_data == {96'h0, {24{$past(m_lo[7])}}, $past(m_lo)})
        else $error("signed byte load not sign extended");
    a_ubyte_zero: assert property (req_valid && req_op == OP_LD_BYTE_U
        |=> rsp_data == {120'h0, $past(m_lo)})
        else $error("unsigned byte load not zero extended");
    a_literal_ext: assert property (req_valid && req_op == OP_LITERAL
        |=> rsp_data == {123'h0, $past(req_literal)})
        else $error("literal not zero extended");
    a_ustore_no_ovf: assert property (req_valid &&
        req_op inside {OP_ST_BYTE_U, OP_ST_HALF_U} |=> !rsp_overflow)
        else $error("unsigned store reported overflow");
    a_sbyte_ovf: assert property (req_valid && req_op == OP_ST_BYTE_S
        |=> rsp_overflow == !$past(sb_fit) && rsp_data[7:0] == $past(w_lo)
        && rsp_byte_en == 16'h0001)
        else $error("signed byte store truncation or overflow wrong");
    a_fault_has_ovf: assert property (rsp_ovf_fault |-> rsp_overflow)
        else $error("overflow fault without overflow");
    a_unal_quiet: assert property (rsp_unal_fault |-> !rsp_overflow
        && rsp_byte_en == 16'h0000 && rsp_data == 128'h0)
        else $error("unaligned fault response not empty");
    c_sign_load: cover property (req_valid && req_op == signed_byte_load);
    c_ovf_fault: cover property (rsp_ovf_fault);
    c_unal_fault: cover property (rsp_unal_fault);
endmodule

bind load_store_data_formatter lsdf_monitor u_mon (.pclk, .presetn,
    .req_valid, .req_op, .req_literal, .req_wdata, .mem_rdata, .rsp_valid,
    .rsp_data, .rsp_byte_en, .rsp_overflow, .rsp_ovf_fault, .rsp_unal_fault);

//--- mem_model.sv
// Purpose: memory side model feeding load bytes to the formatter
// Assumes: combinational read of a 32 byte space that wraps
// Notes:   bytes 8..11 hold negative and positive samples
module mem_model (
    input  wire logic [31:0]  addr,
    output logic      [127:0] rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  bytes [0:31];
    logic [95:0] pat;
    // fixed contents, beyond the pattern each byte holds its own address
    initial begin
        pat = 96'h85A57AFA_F0DEBC9A_78563412;
        for (int i = 0; i < 32; i++) begin
            bytes[i] = (i < 12) ? pat[8*i+:8] : 8'(i);
        end
    end
    // lane i carries byte addr+i, lowest address in bits 7:0
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            rdata[8*i+:8] = bytes[5'(addr[4:0] + 5'(i))];
        end
    end
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the load store data formatter
// Assumes: zero wait APB slave, one cycle response latency
// Notes:   checks response data masked to the lanes a store writes
module testbench
    import lsdf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         req_valid, rsp_valid, rsp_overflow, rsp_ovf_fault, er;
    logic         rsp_unal_fault, rsp_reg_misaligned;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, rd, req_addr;
    logic [4:0]   req_reg_num, req_literal;
    logic [127:0] req_wdata, mem_rdata, rsp_data, msk;
    logic [15:0]  rsp_byte_en;
    op_t          req_op;
    int           fail_count, compares, cyc;

    load_store_data_formatter DUT (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .req_valid,
        .req_op, .req_addr, .req_reg_num, .req_literal, .req_wdata,
        .mem_rdata, .rsp_valid, .rsp_data, .rsp_byte_en, .rsp_overflow,
        .rsp_ovf_fault, .rsp_unal_fault, .rsp_reg_misaligned);
    mem_model mem (.addr(req_addr), .rdata(mem_rdata));

    always #10 pclk = ~pclk;

    task finish_test;
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task chk(input logic [127:0] g, input logic [127:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, g, e);
        end
    endtask

    // hang guard, the whole run needs about a hundred cycles
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            finish_test();
        end
    end

    // apb transfer: setup, access held until pready, then release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    // one request pulse; flags are {ovf, ovf fault, unal fault, misal}
    task rq(input op_t op, input logic [31:0] a, input logic [4:0] rn,
            input logic [127:0] wd, input logic [127:0] ex,
            input logic [3:0] fl);
        @(posedge pclk);
        req_valid <= 1'h1;
        req_op <= op;
        req_addr <= a;
        req_reg_num <= rn;
        req_wdata <= wd;
        req_literal <= wd[4:0];
        @(posedge pclk);
        req_valid <= 1'h0;
        #1;
        chk(rsp_valid, 128'h1);
        chk(rsp_data & msk, ex);
        chk({rsp_overflow, rsp_ovf_fault, rsp_unal_fault,
             rsp_reg_misaligned}, fl);
    endtask

    // reset values, unmapped address refused
    task t_regs;
        for (int i = 0; i < 4; i++) begin
            apb(1'h0, 12'(4 * i), 32'h0);
            chk(rd, 128'h0);
        end
        apb(1'h0, 12'h010, 32'h0);
        chk({er, rd}, 128'h1_00000000);
    endtask

    task t_loads;
        rq(signed_byte_load, 8, 0, 0, 128'hFFFFFFFA, 0);
        rq(signed_byte_load, 9, 0, 0, 128'h7A, 0);
        rq(OP_LD_BYTE_U, 8, 0, 0, 128'hFA, 0);
        rq(signed_halfword_load, 10, 0, 0, 128'hFFFF85A5, 0);
        rq(OP_LD_HALF_U, 10, 0, 0, 128'h85A5, 0);
        rq(OP_LD_WORD, 0, 0, 0, 128'h78563412, 0);
        rq(double_word_load, 0, 4, 0, 128'hF0DEBC9A_78563412, 0);
        rq(OP_LD_TRIPLE, 0, 4, 0, {32'h0, pat3()}, 0);
        rq(OP_LD_QUAD, 0, 8, 0, {32'h0F0E0D0C, pat3()}, 0);
        rq(OP_LD_QUAD, 0, 2, 0, {32'h0F0E0D0C, pat3()}, 4'h1);
        rq(OP_LITERAL, 0, 0, 31, 128'h1F, 0);
    endtask

    function automatic logic [95:0] pat3();
        return 96'h85A57AFA_F0DEBC9A_78563412;
    endfunction

    task t_endian;
        apb(1'h1, 12'h004, 32'h1);
        rq(OP_LD_WORD, 0, 0, 0, 128'h12345678, 0);
        rq(OP_LD_HALF_U, 2, 0, 0, 128'h5678, 0);
        rq(double_word_load, 0, 4, 0, 128'h9ABCDEF0_12345678, 0);
        rq(OP_LD_BYTE_U, 0, 0, 0, 128'h12, 0);
        msk = 128'hFFFFFFFF;
        rq(OP_ST_WORD, 0, 0, 128'h12345678, 128'h78563412, 0);
        apb(1'h1, 12'h004, 32'h0);
        rq(OP_ST_WORD, 0, 0, 128'h12345678, 128'h12345678, 0);
        msk = '1;
        rq(OP_ST_QUAD, 0, 8, {32'h0F0E0D0C, pat3()},
           {32'h0F0E0D0C, pat3()}, 0);
    endtask

    // narrow stores: truncation, overflow, mask selects flag or fault
    task t_stores;
        msk = 128'hFF;
        rq(OP_ST_BYTE_S, 0, 0, 128'h180, 128'h80, 4'hC);
        rq(OP_ST_BYTE_S, 0, 0, 128'hFFFFFF80, 128'h80, 0);
        rq(OP_ST_BYTE_U, 0, 0, 128'h180, 128'h80, 0);
        msk = 128'hFFFF;
        rq(OP_ST_HALF_S, 0, 0, 128'h8000, 128'h8000, 4'hC);
        rq(OP_ST_HALF_U, 0, 0, 128'h12345, 128'h2345, 0);
        msk = 128'hFF;
        apb(1'h1, 12'h000, 32'h2);
        rq(OP_ST_BYTE_S, 0, 0, 128'h180, 128'h80, 4'h8);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 128'h3);
        apb(1'h1, 12'h000, 32'h3);
        apb(1'h0, 12'h000, 32'h0);
        chk(rd, 128'h2);
        msk = '1;
    endtask

    // unaligned word completes, then faults once enabled
    task t_unal;
        rq(OP_LD_WORD, 1, 0, 0, 128'h9A785634, 0);
        apb(1'h1, 12'h004, 32'h2);
        rq(OP_LD_WORD, 1, 0, 0, 128'h0, 4'h2);
        // status keeps the fault cause; 26 requests were made so far
        apb(1'h0, 12'h008, 32'h0);
        chk(rd, 128'h1);
        apb(1'h0, 12'h00C, 32'h0);
        chk(rd, 128'h1A);
        apb(1'h1, 12'h004, 32'h0);
    endtask

    initial begin
        {pclk, presetn, psel, penable, pwrite, req_valid} = '0;
        {paddr, pwdata, req_addr, req_reg_num, req_literal} = '0;
        req_wdata = '0;
        req_op = OP_LD_WORD;
        msk = '1;
        repeat (6) @(posedge pclk);
        presetn <= 1'h1;
        t_regs;
        t_loads;
        t_endian;
        t_stores;
        t_unal;
        finish_test;
    end
endmodule
